/* File: design/ccbe_pkg.sv */
// Shared constants and carriers for the call/compare/decimal-adjust executor.
// Assumes a core that hands over one 16-bit instruction word per accepted slot.
package ccbe_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int PC_W = 21;
   localparam int K_W = 20;
   localparam int BANK_W = 6;
   localparam int DADDR_W = 14;

   // ----------------------------------------------------------------
   // Opcode fields
   // ----------------------------------------------------------------
   localparam logic [6:0] OPC_CALL = 7'h76;      // Word[15:9]
   localparam logic [6:0] OPC_CMP_LESS = 7'h30;  // Word[15:9]
   localparam logic [15:0] OPC_DEC_ADJ = 16'h0007;
   localparam logic [3:0] OPC_MOVE_PAIR = 4'hc;  // Word[15:12]
   localparam logic [7:0] OPC_GOTO = 8'hef;      // Word[15:8]
   localparam logic [7:0] OPC_LOAD_PTR = 8'hee;  // Word[15:8]
   localparam int SAVE_BIT = 8;                  // Shadow-save option
   localparam int ACC_BIT = 8;                   // Access-select bit

   // ----------------------------------------------------------------
   // Flag positions and arithmetic constants
   // ----------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_DIG_C = 1;
   localparam logic [PC_W-1:0] RET_OFS = 21'h000004;
   localparam logic [PC_W-1:0] WORD_STEP = 21'h000002;
   localparam logic [4:0] BCD_MAX = 5'h09;
   localparam logic [4:0] BCD_FIX = 5'h06;
   localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 6'h00;
   localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 6'h3f;
   localparam logic [7:0] ACCESS_SPLIT_RST = 8'h60;

   // ----------------------------------------------------------------
   // Register offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_ACC = 4'h0;
   localparam logic [3:0] REG_FLAGS = 4'h1;
   localparam logic [3:0] REG_BANK = 4'h2;
   localparam logic [3:0] REG_ACC_SH = 4'h3;
   localparam logic [3:0] REG_FLAGS_SH = 4'h4;
   localparam logic [3:0] REG_BANK_SH = 4'h5;
   localparam logic [3:0] REG_PC_L = 4'h6;
   localparam logic [3:0] REG_PC_H = 4'h7;
   localparam logic [3:0] REG_PC_U = 4'h8;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 6'h00;
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;

   // ----------------------------------------------------------------
   // Sequencer states and carriers
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_CALL_HI = 2'b01,
      ST_CMP_WAIT = 2'b10,
      ST_SKIP = 2'b11
   } ccbe_state_e;

   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } ccbe_instr_s;

   typedef struct packed {
      logic push;
      logic [PC_W-1:0] addr;
   } ccbe_push_s;

   typedef struct packed {
      logic rd;
      logic [DADDR_W-1:0] addr;
   } ccbe_dmem_s;

endpackage : ccbe_pkg

/* File: design/ccbe_daw_unit.sv */
// Combinational packed-BCD correction of the accumulator.
// Assumes the caller registers the result; no state is held here.
`timescale 1ns/1ps
`default_nettype none

module ccbe_adj_unit (
   input wire logic [7:0] i_acc, // Accumulator before correction
   input wire logic i_dig_c,     // Digit carry flag
   input wire logic i_c,         // Carry flag
   output logic [7:0] o_acc,     // Corrected accumulator
   output logic o_c              // New carry flag
);
   import ccbe_pkg::*;

   logic lo_fix;
   logic hi_fix;
   logic [4:0] lo_sum;
   logic [4:0] hi_dig;
   logic [4:0] hi_sum;

   // Both nibbles in one process so o_acc keeps a single driver; the low
   // nibble gets +6 on a non-decimal digit or a digit carry, the high nibble
   // always takes the digit carry and the +6 only when needed
   always_comb begin
      lo_sum = {1'b0, i_acc[3:0]} + BCD_FIX;
      lo_fix = ({1'b0, i_acc[3:0]} > BCD_MAX) | i_dig_c;
      o_acc[3:0] = lo_fix ? lo_sum[3:0] : i_acc[3:0];
      hi_dig = {1'b0, i_acc[7:4]} + {4'h0, i_dig_c};
      hi_sum = hi_dig + BCD_FIX;
      hi_fix = (hi_dig > BCD_MAX) | i_c;
      o_acc[7:4] = hi_fix ? hi_sum[3:0] : hi_dig[3:0];
      o_c = hi_fix & hi_sum[4];
   end

endmodule : ccbe_adj_unit

`default_nettype wire

/* File: design/ccbe_exec.sv */
// Executes subroutine call, compare-and-skip-if-less and decimal adjust.
// Assumes fetch presents words in order with valid/ready, refetches on
// o_flush, the return stack takes o_push, data memory answers in the same
// clock as o_dmem.rd, and software uses the plain register port.
//
// What this block does
// - Call takes 20-bit target plus save bit.
// - Call pushes PC plus four onto stack.
// - Save bit set copies accumulator, flags, bank.
// - Save bit clear leaves shadow registers alone.
// - Target loads PC bits 20:1, bit 0 zero.
// - Call occupies two cycles, second is refill.
// - Compare subtracts unsigned, writes no result, flags.
// - Byte below accumulator discards next fetched instruction.
// - Compare: two cycles, three when skipping a one-word instruction.
// - Access bit zero uses fixed access bank.
// - Access bit one uses bank select register.
// - File address is eight bits, 0 to 255.
// - Low nibble gets six when above nine.
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module ccbe_exec #(
   parameter logic [7:0] ACCESS_SPLIT = ccbe_pkg::ACCESS_SPLIT_RST // Access bank split
) (
   input wire logic i_core_clk,                  // Core clock, 50 MHz
   input wire logic i_rst_n,                     // Synchronous reset, active low
   input wire ccbe_pkg::ccbe_instr_s i_instr,    // Instruction word from fetch
   output logic o_instr_ready,                   // Slot open for a word
   output logic [ccbe_pkg::PC_W-1:0] o_pc,       // Program counter
   output logic o_flush,                         // Refetch from o_pc
   output logic o_discard,                       // Accepted word run as no-op
   output ccbe_pkg::ccbe_push_s o_push,          // Return stack push
   output ccbe_pkg::ccbe_dmem_s o_dmem,          // Data memory read request
   input wire logic [7:0] i_dmem_rdata,          // Data byte, in the same clock as rd
   input wire logic [3:0] i_reg_addr,            // Register offset
   input wire logic [7:0] i_reg_wdata,           // Register write data
   input wire logic i_reg_wr,                    // Register write strobe
   input wire logic i_reg_rd,                    // Register read strobe
   output logic [7:0] o_reg_rdata,               // Read data, a clock later
   output logic [7:0] o_acc,                     // Accumulator
   output logic [7:0] o_flags,                   // Flags register
   output logic [ccbe_pkg::BANK_W-1:0] o_bank_sel // Bank select register
);
   import ccbe_pkg::*;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // A zero split would leave the low access window empty
   if (ACCESS_SPLIT == 8'h00) begin : g_bad_split
      $error("ACCESS_SPLIT must be above zero");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ccbe_state_e state_ff;
   ccbe_state_e nxt_state;
   logic ready_ff;
   logic [PC_W-1:0] pc_ff;
   logic [7:0] acc_ff;
   logic [7:0] flags_ff;
   logic [BANK_W-1:0] bank_sel_ff;
   logic [7:0] acc_sh_ff;
   logic [7:0] flags_sh_ff;
   logic [BANK_W-1:0] bank_sh_ff;
   logic [7:0] k_lo_ff;
   logic skip_more_ff;
   logic flush_ff;
   logic discard_ff;
   ccbe_push_s push_ff;
   ccbe_dmem_s dmem_ff;
   logic [7:0] rdata_ff;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [15:0] word;
   logic accept;
   logic run_acc;
   logic call_lo;
   logic call_hi;
   logic cmp_go;
   logic adj_go;
   logic skip_acc;
   logic cmp_less;
   logic [8:0] cmp_diff;
   logic [DADDR_W-1:0] cmp_addr;
   logic [K_W-1:0] target;
   logic [7:0] adj_acc;
   logic adj_c;

   // Words that carry a second word behind them
   function automatic logic is_two_word(input logic [15:0] wd);
      is_two_word = (wd[15:12] == OPC_MOVE_PAIR) || (wd[15:9] == OPC_CALL) ||
                    (wd[15:8] == OPC_GOTO) || (wd[15:8] == OPC_LOAD_PTR);
   endfunction : is_two_word

   // Slot handshake and opcode match
   assign word = i_instr.word;
   assign accept = i_instr.valid & ready_ff;
   assign run_acc = accept && (state_ff == ST_RUN);
   assign call_lo = run_acc && (word[15:9] == OPC_CALL);
   assign call_hi = accept && (state_ff == ST_CALL_HI);
   assign cmp_go = run_acc && (word[15:9] == OPC_CMP_LESS);
   assign adj_go = run_acc && (word == OPC_DEC_ADJ);
   assign skip_acc = accept && (state_ff == ST_SKIP);

   // Target literal: high twelve bits ride in the second word
   assign target = {word[11:0], k_lo_ff};

   // Operand address; the access window splits between two fixed banks
   always_comb begin
      if (word[ACC_BIT]) begin
         cmp_addr = {bank_sel_ff, word[7:0]};
      end else if (word[7:0] < ACCESS_SPLIT) begin
         cmp_addr = {ACCESS_LO_BANK, word[7:0]};
      end else begin
         cmp_addr = {ACCESS_HI_BANK, word[7:0]};
      end
   end

   // Borrow of byte minus accumulator decides the skip, nothing is stored
   assign cmp_diff = {1'b0, i_dmem_rdata} - {1'b0, acc_ff};
   assign cmp_less = (state_ff == ST_CMP_WAIT) && cmp_diff[8];

   // BCD correction datapath
   ccbe_adj_unit u_adj (
      .i_acc(acc_ff),
      .i_dig_c(flags_ff[FLAG_DIG_C]),
      .i_c(flags_ff[FLAG_C]),
      .o_acc(adj_acc),
      .o_c(adj_c)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   // Next state per instruction slot
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: begin
            if (call_lo) begin
               nxt_state = ST_CALL_HI;
            end else if (cmp_go) begin
               nxt_state = ST_CMP_WAIT;
            end
         end
         ST_CALL_HI: begin
            if (accept) begin
               nxt_state = ST_RUN;
            end
         end
         ST_CMP_WAIT: begin
            nxt_state = cmp_less ? ST_SKIP : ST_RUN;
         end
         ST_SKIP: begin
            if (accept && (skip_more_ff || !is_two_word(word))) begin
               nxt_state = ST_RUN;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Slot closes for one clock while the operand byte is read
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= !cmp_go;
      end
   end

   // A skipped two-word instruction also drops its second word
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         skip_more_ff <= 1'b0;
      end else if (skip_acc) begin
         skip_more_ff <= !skip_more_ff && is_two_word(word);
      end
   end

   // Discarded slots execute as no-operation
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         discard_ff <= 1'b0;
      end else begin
         discard_ff <= skip_acc;
      end
   end

   // ----------------------------------------------------------------
   // Subroutine call
   // ----------------------------------------------------------------
   // Low target byte is held until the second word arrives
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         k_lo_ff <= 8'h00;
      end else if (call_lo) begin
         k_lo_ff <= word[7:0];
      end
   end

   // Return address follows both call words
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         push_ff <= '0;
      end else begin
         push_ff.push <= call_lo;
         if (call_lo) begin
            push_ff.addr <= pc_ff + RET_OFS;
         end
      end
   end

   // Shadow copy only on request; otherwise the old contents stay
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         acc_sh_ff <= ACC_RST;
         flags_sh_ff <= FLAGS_RST;
         bank_sh_ff <= BANK_RST;
      end else if (call_lo && word[SAVE_BIT]) begin
         acc_sh_ff <= acc_ff;
         flags_sh_ff <= flags_ff;
         bank_sh_ff <= bank_sel_ff;
      end
   end

   // Counter steps one word per slot; the call target replaces it
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         pc_ff <= PC_RST;
      end else if (call_hi) begin
         pc_ff <= {target, 1'b0};
      end else if (accept) begin
         pc_ff <= pc_ff + WORD_STEP;
      end
   end

   // Pipeline refill after the second call word
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         flush_ff <= 1'b0;
      end else begin
         flush_ff <= call_hi;
      end
   end

   // ----------------------------------------------------------------
   // Compare operand fetch
   // ----------------------------------------------------------------
   // One-clock read strobe beside the operand address
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         dmem_ff <= '0;
      end else begin
         dmem_ff.rd <= cmp_go;
         if (cmp_go) begin
            dmem_ff.addr <= cmp_addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // Architectural registers
   // ----------------------------------------------------------------
   // Execution beats a software write landing in the same clock
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         acc_ff <= ACC_RST;
      end else if (adj_go) begin
         acc_ff <= adj_acc;
      end else if (i_reg_wr && (i_reg_addr == REG_ACC)) begin
         acc_ff <= i_reg_wdata;
      end
   end

   // Decimal adjust touches only the carry bit
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         flags_ff <= FLAGS_RST;
      end else if (adj_go) begin
         flags_ff[FLAG_C] <= adj_c;
      end else if (i_reg_wr && (i_reg_addr == REG_FLAGS)) begin
         flags_ff <= i_reg_wdata;
      end
   end

   // Bank select is steered by software only
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         bank_sel_ff <= BANK_RST;
      end else if (i_reg_wr && (i_reg_addr == REG_BANK)) begin
         bank_sel_ff <= i_reg_wdata[BANK_W-1:0];
      end
   end

   // Read data valid only in the clock after the strobe; holes read zero
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rdata_ff <= 8'h00;
      end else if (!i_reg_rd) begin
         rdata_ff <= 8'h00;
      end else begin
         unique case (i_reg_addr)
            REG_ACC: rdata_ff <= acc_ff;
            REG_FLAGS: rdata_ff <= flags_ff;
            REG_BANK: rdata_ff <= {2'b00, bank_sel_ff};
            REG_ACC_SH: rdata_ff <= acc_sh_ff;
            REG_FLAGS_SH: rdata_ff <= flags_sh_ff;
            REG_BANK_SH: rdata_ff <= {2'b00, bank_sh_ff};
            REG_PC_L: rdata_ff <= pc_ff[7:0];
            REG_PC_H: rdata_ff <= pc_ff[15:8];
            REG_PC_U: rdata_ff <= {3'b000, pc_ff[20:16]};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_instr_ready = ready_ff;
   assign o_pc = pc_ff;
   assign o_flush = flush_ff;
   assign o_discard = discard_ff;
   assign o_push = push_ff;
   assign o_dmem = dmem_ff;
   assign o_reg_rdata = rdata_ff;
   assign o_acc = acc_ff;
   assign o_flags = flags_ff;
   assign o_bank_sel = bank_sel_ff;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Push carries the address two words past the call
   AST_CALL_PUSH: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      call_lo |=> (o_push.push && (o_push.addr == $past(pc_ff) + RET_OFS)))
      else $error("call push address wrong");

   // Save bit set copies all three registers
   AST_SHADOW_SAVE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (call_lo && word[SAVE_BIT]) |=>
         ((acc_sh_ff == $past(acc_ff)) && (flags_sh_ff == $past(flags_ff)) &&
          (bank_sh_ff == $past(bank_sel_ff))))
      else $error("shadow copy missing");

   // Save bit clear leaves shadows untouched
   AST_SHADOW_KEEP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (call_lo && !word[SAVE_BIT]) |=>
         ($stable(acc_sh_ff) && $stable(flags_sh_ff) && $stable(bank_sh_ff)))
      else $error("shadow changed without save");

   // Second call word loads the target into bits 20:1 and flushes
   AST_CALL_TARGET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      call_hi |=> ((pc_ff == {$past(target), 1'b0}) && o_flush))
      else $error("call target not loaded");

   // Call spans exactly the first and the second word
   AST_CALL_TWO: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      call_lo |=> (state_ff == ST_CALL_HI) ##0 (!o_flush))
      else $error("call did not wait for second word");

   // Compare alters neither accumulator nor flags
   AST_CMP_NO_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      ((state_ff == ST_CMP_WAIT) && !i_reg_wr) |=> ($stable(acc_ff) && $stable(flags_ff)))
      else $error("compare changed state");

   // Less-than leads to a discarded slot; otherwise back to run
   AST_CMP_SKIP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (state_ff == ST_CMP_WAIT) |=>
         ((state_ff == ST_SKIP) == ($past(i_dmem_rdata) < $past(acc_ff))))
      else $error("skip decision wrong");

   // Access bit one takes the operand address from the bank select register
   AST_CMP_ADDR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (cmp_go && word[ACC_BIT]) |=>
         (o_dmem.rd && (o_dmem.addr == {$past(bank_sel_ff), $past(word[7:0])})))
      else $error("banked operand address wrong");

   // A second word of a skipped pair is discarded as well
   AST_SKIP_PAIR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (skip_acc && !skip_more_ff && is_two_word(word)) |=> (state_ff == ST_SKIP))
      else $error("two-word skip ended early");

   // Decimal digit with no carry keeps the low nibble
   AST_ADJ_LOW: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (adj_go && (acc_ff[3:0] <= 4'h9) && !flags_ff[FLAG_DIG_C]) |=>
         ((acc_ff[3:0] == $past(acc_ff[3:0])) && $stable(flags_ff[FLAG_DIG_C])))
      else $error("low nibble changed");

endmodule : ccbe_exec

`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the call, compare-skip and decimal-adjust executor.
// Assumes ccbe_pkg and ccbe_exec are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import ccbe_pkg::*;

   // ----------------------------------------------------------------
   // Signals and bench state
   // ----------------------------------------------------------------
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   ccbe_instr_s instr = '0;
   logic [7:0] dmem_rdata = 8'h00;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic instr_ready, flush, discard;
   logic [PC_W-1:0] pc, push_a, exp_pc;
   ccbe_push_s push;
   ccbe_dmem_s dmem;
   logic [DADDR_W-1:0] dm_a;
   logic [7:0] reg_rdata, acc, flags, sh_acc, sh_fl;
   logic [BANK_W-1:0] bank, sh_bank;
   logic [15:0] lfsr = 16'hdcc6;
   int fail_count = 0;
   int cmp_count = 0;
   int push_n = 0;
   int disc_n = 0;
   int flush_n = 0;

   // Free-running core clock, 20 ns period
   initial begin
      forever #10 i_core_clk = ~i_core_clk;
   end

   ccbe_exec DUT (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_instr(instr),
      .o_instr_ready(instr_ready), .o_pc(pc), .o_flush(flush), .o_discard(discard),
      .o_push(push), .o_dmem(dmem), .i_dmem_rdata(dmem_rdata), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .o_reg_rdata(reg_rdata), .o_acc(acc), .o_flags(flags), .o_bank_sel(bank)
   );

   // Pulse monitor: counts one-cycle pulses so no checker has to hit the exact cycle
   always @(posedge i_core_clk) begin
      if (push.push === 1'b1) begin
         push_n++;
         push_a = push.addr;
      end
      if (discard === 1'b1) disc_n++;
      if (flush === 1'b1) flush_n++;
      if (dmem.rd === 1'b1) dm_a = dmem.addr;
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction : rnd

   // Expected {carry, accumulator}; no carry from low into high nibble
   function automatic logic [8:0] adj_exp(input logic [7:0] a, input logic [7:0] f);
      logic [4:0] lo, hi;
      logic fix;
      lo = {1'b0, a[3:0]};
      if (lo > 5'h09 || f[1]) lo = lo + 5'h06;
      hi = {1'b0, a[7:4]} + {4'h0, f[1]};
      fix = (hi > 5'h09) || f[0];
      if (fix) hi = hi + 5'h06;
      return {fix & hi[4], hi[3:0], lo[3:0]};
   endfunction : adj_exp

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask : tick

   // Each strobe task ends one edge after lowering, so strobes never collide
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_core_clk);
      reg_wr <= 1'b0;
      @(posedge i_core_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_core_clk);
      reg_rd <= 1'b0;
      @(posedge i_core_clk);
      d = reg_rdata;
   endtask : rd

   task automatic set_regs(input logic [7:0] a, input logic [7:0] f, input logic [5:0] b);
      wr(REG_ACC, a);
      wr(REG_FLAGS, f);
      wr(REG_BANK, {2'b00, b});
      chk(acc, a);
      chk(flags, f);
      chk(bank, b);
   endtask : set_regs

   // Valid stays up across back-to-back words; a bounded wait guards a stuck slot
   task automatic send(input logic [15:0] w);
      int n;
      n = 0;
      instr <= {1'b1, w};
      do begin
         @(posedge i_core_clk);
         n++;
      end while (instr_ready !== 1'b1 && n < 16);
      if (n >= 16) fail_count++;
      exp_pc = exp_pc + 21'h000002;
   endtask : send

   task automatic idle();
      instr <= '0;
      @(posedge i_core_clk);
   endtask : idle

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude

   // Watchdog: the tests need a few hundred cycles, so 20000 means a hang
   initial begin
      repeat (20000) @(posedge i_core_clk);
      fail_count++;
      conclude();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin : main
      logic [7:0] d, a8, f8, fl, r;
      logic [19:0] k;
      logic [8:0] e;
      logic [5:0] b6;
      logic s, ab, two;
      int dn;
      repeat (3) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      exp_pc = PC_RST;
      sh_acc = 8'h00;
      sh_fl = 8'h00;
      sh_bank = 6'h00;
      tick(2);
      // Read-only and unmapped offsets ignore writes
      wr(4'h3, 8'h5a);
      wr(4'h9, 8'hff);
      for (int i = 0; i < 10; i++) begin
         rd(i[3:0], d);
         chk(d, 0);
      end
      $display("Test reset done");
      // Calls with both save-bit values and the target range ends
      for (int i = 0; i < 4; i++) begin
         a8 = rnd();
         fl = rnd();
         r = rnd();
         b6 = r[5:0];
         s = i[0] ^ i[1];
         k = (i == 0) ? 20'hfffff : (i == 1) ? 20'h00000 : {b6[3:0], rnd(), rnd()};
         set_regs(a8, fl, b6);
         dn = push_n;
         send({7'h76, s, k[7:0]});
         send({4'hf, k[19:8]});
         idle();
         tick(2);
         chk(push_n, dn + 1);
         chk(push_a, exp_pc);
         chk(flush_n, push_n);
         exp_pc = {k, 1'b0};
         chk(pc, exp_pc);
         if (s) begin
            sh_acc = a8;
            sh_fl = fl;
            sh_bank = b6;
         end
         rd(REG_ACC_SH, d);
         chk(d, sh_acc);
         rd(REG_FLAGS_SH, d);
         chk(d, sh_fl);
         rd(REG_BANK_SH, d);
         chk(d, sh_bank);
      end
      $display("Test call done");
      // Compare-skip over one- and two-word followers, equal and split-boundary cases
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         ab = r[0];
         two = r[1];
         b6 = r[7:2];
         a8 = rnd();
         d = (i == 0) ? a8 : rnd();
         f8 = (i == 1) ? 8'h5f : (i == 2) ? 8'h60 : (i == 3) ? 8'hff : rnd();
         fl = rnd();
         set_regs(a8, fl, b6);
         dmem_rdata <= d;
         dn = disc_n;
         send({7'h30, ab, f8});
         send(two ? 16'hc000 : 16'h0000);
         if (two) send(16'hf000);
         send(16'h0000);
         idle();
         tick(3);
         dmem_rdata <= ~d;
         chk(dm_a, ab ? {b6, f8} : {((f8 < 8'h60) ? 6'h00 : 6'h3f), f8});
         chk(disc_n - dn, (d < a8) ? (two ? 2 : 1) : 0);
         chk(acc, a8);
         chk(flags, fl);
         chk(pc, exp_pc);
      end
      $display("Test compare done");
      // Decimal adjust, result checked one cycle after the word is taken
      for (int i = 0; i < 16; i++) begin
         a8 = (i == 0) ? 8'ha5 : (i == 1) ? 8'hce : (i == 2) ? 8'h99 : rnd();
         fl = (i < 2) ? 8'h00 : (i == 2) ? 8'h03 : rnd();
         set_regs(a8, fl, b6);
         send(OPC_DEC_ADJ);
         idle();
         e = adj_exp(a8, fl);
         chk(acc, e[7:0]);
         chk(flags, {fl[7:1], e[8]});
      end
      chk(pc, exp_pc);
      $display("Test decimal adjust done");
      conclude();
   end : main

endmodule : tb_top

`default_nettype wire
